//--- verilog/oag_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.svh"

module oag_top
    import oag_pkg::*;
(
    input  wire logic        clock,         // Core clock, 200 MHz
    input  wire logic        arst_n,        // Asynchronous reset, low
    input  wire oag_req_s    req,           // Operand request
    output oag_res_s         res,           // Registered address result
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read response valid
    input  wire logic        s_axi_rready   // Read response ready
);

    // ============================================================
    // State
    // ============================================================
    oag_state_s state_r;
    oag_state_s state_nxt;

    // ============================================================
    // Control decode
    // ============================================================
    logic [3:0]  x_pointer_select;
    logic [3:0]  y_pointer_select;
    logic [3:0]  brev_pointer_select;
    logic        x_circular_enable;
    logic        y_circular_enable;
    logic        x_on;
    logic        y_on;
    logic        brev_on;

    always_comb
    begin
        x_pointer_select    = state_r.ctrl[`OAG_XSEL_LSB +: 4];
        y_pointer_select    = state_r.ctrl[`OAG_YSEL_LSB +: 4];
        brev_pointer_select = state_r.ctrl[`OAG_BSEL_LSB +: 4];
        x_circular_enable   = state_r.ctrl[`OAG_XEN_BIT];
        y_circular_enable   = state_r.ctrl[`OAG_YEN_BIT];
        x_on    = x_circular_enable
                  && (x_pointer_select != `OAG_SEL_OFF);
        y_on    = y_circular_enable
                  && (y_pointer_select != `OAG_SEL_OFF);
        brev_on = state_r.brev[`OAG_BREN_BIT]
                  && (brev_pointer_select != `OAG_SEL_OFF);
    end

    // ============================================================
    // Address arithmetic
    // ============================================================
    function automatic logic [15:0] rev16(input logic [15:0] v);
        return {<<{v}};
    endfunction

    oag_space_e  space;
    logic        illegal;
    logic        mac_ptr_ok;
    logic        mac_mod_ok;
    logic [15:0] mod_abs;
    logic [15:0] step;
    logic [15:0] raw_addr;
    logic        dir_down;
    logic        use_brev;
    logic [15:0] brev_addr;
    logic        x_hit;
    logic        y_hit;
    logic [15:0] x_fixed;
    logic [15:0] y_fixed;
    logic        x_wrap;
    logic        y_wrap;
    logic [15:0] new_addr;
    logic        wrapped;

    always_comb
    begin
        space = req.space;
        mac_ptr_ok = (req.ptr_sel >= `OAG_W8)
                     && (req.ptr_sel <= `OAG_W11);
        mod_abs = req.modifier[15] ? (16'h0000 - req.modifier)
                                   : req.modifier;
        mac_mod_ok = (mod_abs == 16'h0002) || (mod_abs == 16'h0004)
                     || (mod_abs == 16'h0006);
        illegal = 1'b0;
        if (req.cls == OAG_C_MAC)
        begin
            // Pointers 8,9 sit in X read space, 10,11 in Y.
            space = (req.ptr_sel <= `OAG_W9) ? OAG_S_XRD
                                             : OAG_S_Y;
            case (req.mode)
                OAG_M_IND:    illegal = !mac_ptr_ok;
                OAG_M_POST:   illegal = !mac_ptr_ok
                                        || !mac_mod_ok;
                OAG_M_REGOFS: illegal = (req.ptr_sel != `OAG_W9)
                                     && (req.ptr_sel != `OAG_W11);
                default:      illegal = 1'b1;
            endcase
        end
        else if (req.mode == OAG_M_REGOFS)
        begin
            illegal = (req.cls != OAG_C_MOVE)
                      && (req.cls != OAG_C_ACC);
        end

        // The offset register value is one per instruction, used by
        // whichever operand of a move selects indexed mode.
        step = (req.mode == OAG_M_REGOFS) ? req.ofs_val
                                          : req.modifier;
        raw_addr = req.ptr_val + step;
        dir_down = step[15];

        // Reverse-carry add: pointer and scaled brev modifier are both reversed, summed, reversed back.
        use_brev  = brev_on && (space == OAG_S_XWR)
                    && (req.ptr_sel == brev_pointer_select)
                    && ((req.mode == OAG_M_PRE) || (req.mode == OAG_M_POST))
                    && !req.byte_op;
        brev_addr = rev16(rev16({req.ptr_val[15:1], 1'b0})
                    + rev16({state_r.brev[14:0], 1'b0}));
        brev_addr[0] = 1'b0;

        // One buffer per space; bit reversal wins the X write side.
        x_hit = x_on && (req.ptr_sel == x_pointer_select)
                && (space != OAG_S_Y)
                && !(use_brev && space == OAG_S_XWR);
        y_hit = y_on && (req.ptr_sel == y_pointer_select)
                && (space == OAG_S_Y);

        // The stack and frame pointers are accepted as buffer
        // pointers; keeping them out is left to software.
        new_addr = use_brev ? brev_addr
                 : x_hit    ? x_fixed
                 : y_hit    ? y_fixed : raw_addr;
        wrapped  = (x_hit && x_wrap) || (y_hit && y_wrap);
    end

    oag_circ_fix u_x_fix (
        .enable    (x_hit),
        .word_only (1'b0),
        .dir_down  (dir_down),
        .addr_in   (raw_addr),
        .buf_start (state_r.x_start),
        .buf_end   (state_r.x_end),
        .addr_out  (x_fixed),
        .wrapped   (x_wrap)
    );

    oag_circ_fix u_y_fix (
        .enable    (y_hit),
        .word_only (1'b1),
        .dir_down  (dir_down),
        .addr_in   (raw_addr),
        .buf_start (state_r.y_start),
        .buf_end   (state_r.y_end),
        .addr_out  (y_fixed),
        .wrapped   (y_wrap)
    );

    // ============================================================
    // Next state
    // ============================================================
    logic [15:0] wr16;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        wr_hit;

    always_comb
    begin
        state_nxt = state_r;

        // Result: the corrected address appears one edge later.
        state_nxt.res            = '0;
        state_nxt.res.valid      = req.valid;
        state_nxt.res.illegal    = req.valid && illegal;
        state_nxt.res.space      = space;
        state_nxt.res.wb_sel     = req.ptr_sel;
        state_nxt.res.mem_access = req.valid && !illegal
                                   && (req.mode != OAG_M_DIRECT)
                                   && (req.mode != OAG_M_LIT);
        case (req.cls)
            OAG_C_BRANCH:
            begin
                state_nxt.res.literal = req.modifier;
                state_nxt.res.ea = req.ptr_val + req.modifier;
            end
            OAG_C_INTERRUPT_DISABLE_INSTRUCTION:
            begin
                state_nxt.res.literal = req.modifier
                                        & `OAG_INTERRUPT_DISABLE_INSTRUCTION_MASK;
            end
            default:
            begin
                state_nxt.res.literal = req.modifier;
                case (req.mode)
                    OAG_M_DIRECT: state_nxt.res.ea = req.ptr_val;
                    OAG_M_IND:    state_nxt.res.ea = req.ptr_val;
                    OAG_M_POST:   state_nxt.res.ea = req.ptr_val;
                    OAG_M_PRE:    state_nxt.res.ea = new_addr;
                    OAG_M_REGOFS: state_nxt.res.ea = new_addr;
                    OAG_M_LITOFS: state_nxt.res.ea = new_addr;
                    default:      state_nxt.res.ea = 16'h0000;
                endcase
                state_nxt.res.wb_val = new_addr;
                state_nxt.res.wb_en  = req.valid && !illegal
                                       && ((req.mode == OAG_M_POST)
                                           || (req.mode == OAG_M_PRE));
                state_nxt.res.wrapped = req.valid && wrapped;
            end
        endcase
        if (req.valid)
        begin
            state_nxt.last_ea      = state_nxt.res.ea;
            state_nxt.last_wrap    = wrapped;
            state_nxt.last_illegal = illegal;
        end

        // AXI4-Lite write path: address and data in either order.
        if (s_axi_awvalid && s_axi_awready)
        begin
            state_nxt.aw_got  = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            state_nxt.w_got  = 1'b1;
            state_nxt.w_data = s_axi_wdata;
            state_nxt.w_strb = s_axi_wstrb;
        end
        wr16   = 16'h0000;
        wr_hit = 1'b0;
        if (state_r.aw_got && state_r.w_got && !state_r.bvalid)
        begin
            wr_hit = 1'b1;
            case (state_r.aw_addr)
                `OAG_CTRL_OFS:   wr16 = state_r.ctrl;
                `OAG_XSTART_OFS: wr16 = state_r.x_start;
                `OAG_XEND_OFS:   wr16 = state_r.x_end;
                `OAG_YSTART_OFS: wr16 = state_r.y_start;
                `OAG_YEND_OFS:   wr16 = state_r.y_end;
                `OAG_BREV_OFS:   wr16 = state_r.brev;
                default:         wr_hit = 1'b0;
            endcase
            wr16[7:0]  = state_r.w_strb[0] ? state_r.w_data[7:0]  : wr16[7:0];
            wr16[15:8] = state_r.w_strb[1] ? state_r.w_data[15:8] : wr16[15:8];
            case (state_r.aw_addr)
                `OAG_CTRL_OFS:   state_nxt.ctrl    = wr16;
                `OAG_XSTART_OFS: state_nxt.x_start = wr16;
                `OAG_XEND_OFS:   state_nxt.x_end   = wr16;
                `OAG_YSTART_OFS: state_nxt.y_start = wr16;
                `OAG_YEND_OFS:   state_nxt.y_end   = wr16;
                `OAG_BREV_OFS:   state_nxt.brev    = wr16;
                default:         state_nxt.ctrl    = state_r.ctrl;
            endcase
            state_nxt.aw_got = 1'b0;
            state_nxt.w_got  = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp  = wr_hit ? `OAG_AXI_OKAY : `OAG_AXI_SLVERR;
        end
        if (state_r.bvalid && s_axi_bready)
        begin
            state_nxt.bvalid = 1'b0;
        end

        // Read path: one read in flight, answered the next edge.
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            `OAG_CTRL_OFS:   rd_word[15:0] = state_r.ctrl;
            `OAG_XSTART_OFS: rd_word[15:0] = state_r.x_start;
            `OAG_XEND_OFS:   rd_word[15:0] = state_r.x_end;
            `OAG_YSTART_OFS: rd_word[15:0] = state_r.y_start;
            `OAG_YEND_OFS:   rd_word[15:0] = state_r.y_end;
            `OAG_BREV_OFS:   rd_word[15:0] = state_r.brev;
            `OAG_LASTEA_OFS: rd_word[15:0] = state_r.last_ea;
            `OAG_FLAGS_OFS:  rd_word[1:0]  = {state_r.last_illegal,
                                              state_r.last_wrap};
            default:         rd_hit = 1'b0;
        endcase
        if (s_axi_arvalid && s_axi_arready)
        begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata  = rd_word;
            state_nxt.rresp  = rd_hit ? `OAG_AXI_OKAY : `OAG_AXI_SLVERR;
        end
        else if (state_r.rvalid && s_axi_rready)
        begin
            state_nxt.rvalid = 1'b0;
        end
    end

    // ============================================================
    // Registers
    // ============================================================
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r         <= '0;
            state_r.ctrl    <= `OAG_CTRL_RST;
            state_r.x_start <= `OAG_BUF_RST;
            state_r.x_end   <= `OAG_BUF_RST;
            state_r.y_start <= `OAG_BUF_RST;
            state_r.y_end   <= `OAG_BUF_RST;
            state_r.brev    <= `OAG_BREV_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    always_comb
    begin
        res           = state_r.res;
        s_axi_awready = !state_r.aw_got && !state_r.bvalid;
        s_axi_wready  = !state_r.w_got && !state_r.bvalid;
        s_axi_bvalid  = state_r.bvalid;
        s_axi_bresp   = state_r.bresp;
        s_axi_arready = !state_r.rvalid;
        s_axi_rvalid  = state_r.rvalid;
        s_axi_rdata   = state_r.rdata;
        s_axi_rresp   = state_r.rresp;
    end

endmodule // oag_top

`default_nettype wire

//--- verilog/oag_defines.svh
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH

// ============================================================
// Register byte offsets on the AXI4-Lite slave
// ============================================================
`define OAG_CTRL_OFS     8'h00
`define OAG_XSTART_OFS   8'h04
`define OAG_XEND_OFS     8'h08
`define OAG_YSTART_OFS   8'h0C
`define OAG_YEND_OFS     8'h10
`define OAG_BREV_OFS     8'h14
`define OAG_LASTEA_OFS   8'h18
`define OAG_FLAGS_OFS    8'h1C

// ============================================================
// Control and bit-reverse register fields
// ============================================================
`define OAG_XSEL_LSB     0
`define OAG_YSEL_LSB     4
`define OAG_BSEL_LSB     8
`define OAG_YEN_BIT      14
`define OAG_XEN_BIT      15
`define OAG_BREN_BIT     15
`define OAG_SEL_OFF      4'hF

// ============================================================
// Reset values
// ============================================================
`define OAG_CTRL_RST     16'h0FFF
`define OAG_BUF_RST      16'h0000
`define OAG_BREV_RST     16'h0000

// ============================================================
// Multiply-accumulate pointer registers and constants
// ============================================================
`define OAG_W8           4'h8
`define OAG_W9           4'h9
`define OAG_W10          4'hA
`define OAG_W11          4'hB
`define OAG_INTERRUPT_DISABLE_INSTRUCTION_MASK    16'h3FFF
`define OAG_ADDR_UNIT    16'h0001
`define OAG_AXI_OKAY     2'h0
`define OAG_AXI_SLVERR   2'h2

`endif

//--- verilog/oag_pkg.sv
package oag_pkg;

    typedef enum logic [2:0] {
        OAG_M_DIRECT = 3'h0,
        OAG_M_IND    = 3'h1,
        OAG_M_POST   = 3'h3,
        OAG_M_PRE    = 3'h2,
        OAG_M_REGOFS = 3'h6,
        OAG_M_LITOFS = 3'h7,
        OAG_M_LIT    = 3'h5
    } oag_mode_e;

    typedef enum logic [2:0] {
        OAG_C_MCU    = 3'h0,
        OAG_C_MOVE   = 3'h1,
        OAG_C_ACC    = 3'h3,
        OAG_C_MAC    = 3'h2,
        OAG_C_BRANCH = 3'h6,
        OAG_C_INTERRUPT_DISABLE_INSTRUCTION   = 3'h7
    } oag_class_e;

    typedef enum logic [1:0] {
        OAG_S_XRD = 2'h0,
        OAG_S_XWR = 2'h1,
        OAG_S_Y   = 2'h3
    } oag_space_e;

    typedef struct packed {
        logic        valid;
        oag_class_e  cls;
        oag_mode_e   mode;
        oag_space_e  space;
        logic        byte_op;
        logic [3:0]  ptr_sel;
        logic [15:0] ptr_val;
        logic [3:0]  ofs_field;
        logic [15:0] ofs_val;
        logic [15:0] modifier;
    } oag_req_s;

    typedef struct packed {
        logic        valid;
        logic        illegal;
        oag_space_e  space;
        logic        mem_access;
        logic [15:0] ea;
        logic        wb_en;
        logic [3:0]  wb_sel;
        logic [15:0] wb_val;
        logic [15:0] literal;
        logic        wrapped;
    } oag_res_s;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] x_start;
        logic [15:0] x_end;
        logic [15:0] y_start;
        logic [15:0] y_end;
        logic [15:0] brev;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] last_ea;
        logic        last_wrap;
        logic        last_illegal;
        oag_res_s    res;
    } oag_state_s;

endpackage

//--- verilog/oag_circ_fix.sv
`timescale 1ns/1ps
`default_nettype none
`include "oag_defines.svh"

module oag_circ_fix
    import oag_pkg::*;
(
    input  wire logic        enable,    // Buffer applies to this pointer
    input  wire logic        word_only, // Force word alignment
    input  wire logic        dir_down,  // Step is decrementing
    input  wire logic [15:0] addr_in,   // Modified address
    input  wire logic [15:0] buf_start, // Buffer lower bound
    input  wire logic [15:0] buf_end,   // Buffer upper bound
    output logic      [15:0] addr_out,  // Corrected address
    output logic             wrapped    // A bound was crossed
);

    logic [15:0] span;
    logic [16:0] span_p1;
    logic        pow2;
    logic        over_hi;
    logic        under_lo;
    logic [15:0] fixed;

    always_comb
    begin
        span     = buf_end - buf_start;
        span_p1  = {1'b0, span} + 17'h00001;
        pow2     = ((span_p1 & {1'b0, span}) == 17'h00000);
        over_hi  = (addr_in > buf_end);
        under_lo = (addr_in < buf_start);
        fixed    = addr_in;
        wrapped  = 1'b0;
        if (enable)
        begin
            // Only two-sided when the length is a power of two.
            if (over_hi && (pow2 || !dir_down))
            begin
                fixed   = buf_start + (addr_in - buf_end)
                          - `OAG_ADDR_UNIT;
                wrapped = 1'b1;
            end
            else if (under_lo && (pow2 || dir_down))
            begin
                fixed   = buf_end - (buf_start - addr_in)
                          + `OAG_ADDR_UNIT;
                wrapped = 1'b1;
            end
        end
        addr_out = word_only ? {fixed[15:1], 1'b0} : fixed;
    end

endmodule // oag_circ_fix

`default_nettype wire

//--- tb/oag_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module oag_top_sva
    import oag_pkg::*;
(
    input wire logic     clock,         // Core clock
    input wire logic     arst_n,        // Reset, active low
    input wire oag_req_s req,           // Operand request
    input wire oag_res_s res,           // Address result
    input wire logic     s_axi_arvalid, // Read address valid
    input wire logic     s_axi_arready, // Read address ready
    input wire logic     s_axi_rvalid   // Read data valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Result, multiply-accumulate operand, literal and read-answer checks
    sequence mac_req;
        req.valid && req.cls == OAG_C_MAC;
    endsequence
    sequence mac_ok;
        mac_req ##0 (req.ptr_sel inside {[4'h8:4'hB]} &&
                     req.mode == OAG_M_IND);
    endsequence
    res_follow_a: assert property (req.valid |=> res.valid)
        else $error("result missing after request");
    mac_ptr_a: assert property (
        mac_req ##0 !(req.ptr_sel inside {[4'h8:4'hB]})
        |=> res.illegal && !res.wb_en) else $error("bad pointer taken");
    mac_space_a: assert property (
        mac_ok |=> res.space ==
        ($past(req.ptr_sel) < 4'hA ? OAG_S_XRD : OAG_S_Y))
        else $error("wrong space for pointer");
    mac_index_a: assert property (
        mac_req ##0 (req.mode == OAG_M_REGOFS && !req.ptr_sel[0])
        |=> res.illegal) else $error("indexed on even pointer taken");
    mac_mode_a: assert property (
        mac_req ##0 !(req.mode inside {OAG_M_IND, OAG_M_POST,
        OAG_M_REGOFS}) |=> res.illegal) else $error("bad mode taken");
    ofs_nowb_a: assert property (
        req.valid && req.mode == OAG_M_REGOFS |=> !res.wb_en)
        else $error("indexed mode wrote pointer back");
    interrupt_disable_instruction_lit_a: assert property (
        req.valid && req.cls == OAG_C_INTERRUPT_DISABLE_INSTRUCTION |=>
        res.literal == ($past(req.modifier) & 16'h3FFF))
        else $error("disable literal not 14 bits");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // oag_top_sva
`default_nettype wire

//--- tb/oag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model
    import oag_pkg::*;
(
    input wire logic     clock,  // Core clock
    input wire logic     arst_n, // Reset, active low
    input wire oag_res_s res,    // Address result
    output logic [15:0]  last_ea // Last accessed address
);
    // The memory takes the result address as is, with no wait state.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            last_ea <= 16'h0000;
        else if (res.valid && res.mem_access)
            last_ea <= res.ea;
    end
endmodule // oag_mem_model
`default_nettype wire

//--- tb/oag_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("FAIL %s exp %h got %h", n, e, s); end end
module oag_top_bench;
    import oag_pkg::*;
    localparam logic [15:0] XS = 16'h1000, XE = 16'h10FF;
    logic        clock = 1'b0, arst_n = 1'b0, bad;
    oag_req_s    req = '0;
    oag_res_s    res;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF, p;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] last_ea, md, v;
    int          failures = 0, compares = 0, cyc = 0;
    int          seed = 32'hd0ea16ab;
    oag_mode_e   m;
    oag_top oag_top_inst (.clock, .arst_n, .req, .res, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    oag_mem_model oag_mem_model_inst (.clock, .arst_n, .res, .last_ea);
    always #2.5 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // Bus cycle: address and data offered together, held until taken.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do
        begin
            @(posedge clock);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
    endtask
    function automatic logic [15:0] circ(input logic [15:0] a, s, e);
        return a > e ? s + (a - e) - 16'h1 :
               a < s ? e - (s - a) + 16'h1 : a;
    endfunction
    task automatic op(input oag_class_e c, input oag_mode_e mo,
        input logic [3:0] ps, input logic [15:0] pv, o, mv,
        input oag_space_e sp);
        @(posedge clock);
        req <= '{valid: 1'b1, cls: c, mode: mo, space: sp, byte_op: 1'b0,
                 ptr_sel: ps, ptr_val: pv, ofs_field: 4'h2, ofs_val: o,
                 modifier: mv};
        @(posedge clock);
        req <= '0;
        #1;
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        bus(0, 8'h00, 0);
        `CHK("ctrl reset", 32'h0000_0FFF, d)
        bus(0, 8'h20, 0);
        `CHK("unmapped", 2'h2, rs)
        bus(1, 8'h04, XS);
        bus(1, 8'h08, XE);
        bus(1, 8'h00, 32'h8FF1);
        bus(0, 8'h08, 0);
        `CHK("x end", {16'h0, XE}, d)
        op(OAG_C_MOVE, OAG_M_POST, 1, 16'h10FE, 0, 16'h2, OAG_S_XRD);
        `CHK("post wb", circ(16'h1100, XS, XE), res.wb_val)
        `CHK("wb sel", 4'h1, res.wb_sel)
        `CHK("wrapped", 1'b1, res.wrapped)
        op(OAG_C_MOVE, OAG_M_POST, 1, 16'h10FE, 0, 16'h6, OAG_S_XRD);
        `CHK("overshoot", circ(16'h1104, XS, XE), res.wb_val)
        op(OAG_C_MOVE, OAG_M_PRE, 1, XS, 0, 16'hFFFE, OAG_S_XRD);
        `CHK("pre down", circ(16'h0FFE, XS, XE), res.ea)
        op(OAG_C_ACC, OAG_M_REGOFS, 1, 16'h10F0, 16'h20, 0, OAG_S_XRD);
        `CHK("index ea", circ(16'h1110, XS, XE), res.ea)
        `CHK("index wb", 1'b0, res.wb_en)
        @(posedge clock);
        #1;
        `CHK("mem ea", circ(16'h1110, XS, XE), last_ea)
        bus(0, 8'h18, 0);
        `CHK("last ea", {16'h0, circ(16'h1110, XS, XE)}, d)
        bus(0, 8'h1C, 0);
        `CHK("flags", 32'h0000_0001, d)
        bus(1, 8'h0C, 32'h2000);
        bus(1, 8'h10, 32'h20FF);
        bus(1, 8'h00, 32'h4F2F);
        op(OAG_C_MOVE, OAG_M_POST, 2, 16'h20FE, 0, 16'h3, OAG_S_Y);
        `CHK("y wb", 16'h2000, res.wb_val)
        op(OAG_C_MOVE, OAG_M_POST, 1, 16'h10FE, 0, 16'h2, OAG_S_XRD);
        `CHK("x off", 16'h1100, res.wb_val)
        bus(1, 8'h10, 32'h2009);
        op(OAG_C_MOVE, OAG_M_PRE, 2, 16'h1FF0, 0, 16'h2, OAG_S_Y);
        `CHK("one way", 16'h1FF2, res.ea)
        op(OAG_C_MOVE, OAG_M_PRE, 2, 16'h2000, 0, 16'hFFFE, OAG_S_Y);
        `CHK("down wrap", circ(16'h1FFE, 16'h2000, 16'h2009), res.ea)
        bus(1, 8'h14, 32'h8004);
        bus(1, 8'h00, 32'h432F);
        op(OAG_C_MOVE, OAG_M_PRE, 3, 16'h0008, 0, 16'h2, OAG_S_XWR);
        `CHK("bit rev", 16'h0004, res.ea)
        op(OAG_C_MOVE, OAG_M_PRE, 3, 16'h0008, 0, 16'h2, OAG_S_XRD);
        `CHK("rev read", 16'h000A, res.ea)
        repeat (30)
        begin
            v = 16'($random(seed));
            p = v[3] ? {2'b10, v[5:4]} : v[7:4];
            md = 16'(($random(seed) & 3) * 2);
            m = (v[1:0] == 2'h0) ? OAG_M_REGOFS : oag_mode_e'(v[1:0]);
            op(OAG_C_MAC, m, p, 16'h0800, 16'h10, md, OAG_S_XRD);
            bad = p < 8 || p > 11 || m == OAG_M_PRE ||
                  (m == OAG_M_POST && md == 0) || (m == OAG_M_REGOFS && !p[0]);
            `CHK("mac bad", bad, res.illegal)
            if (!bad)
                `CHK("space", p[1] ? OAG_S_Y : OAG_S_XRD, res.space)
            md = 16'($random(seed));
            v = 16'($random(seed));
            op(OAG_C_INTERRUPT_DISABLE_INSTRUCTION, OAG_M_LIT, 0, v, 0, md, OAG_S_XRD);
            `CHK("disable lit", md & 16'h3FFF, res.literal)
            op(OAG_C_BRANCH, OAG_M_LIT, 0, v, 0, md, OAG_S_XRD);
            `CHK("branch ea", 16'(v + md), res.ea)
            `CHK("branch lit", md, res.literal)
        end
        end_of_test();
    end
endmodule // oag_top_bench
bind oag_top oag_top_sva oag_top_sva_inst (.clock, .arst_n, .req, .res,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
